// [rtl/sync_alarm_pkg.sv]
// Register map, field positions, reset values and timing constants of the status block.
package sync_alarm_pkg;
    localparam int ADDR_WIDTH = 15;
    localparam int DATA_WIDTH = 8;
    localparam int LANE_COUNT = 16;
    localparam int FRAME_WIDTH = 24;
    localparam logic [4:0] FRAME_BITS = 5'h18;
    localparam logic [4:0] HEAD_BITS = 5'h10;

    localparam logic [14:0] ADDR_RETUNE_READBACK = 15'h03e1;
    localparam logic [14:0] ADDR_THERMAL_READING = 15'h0400;
    localparam logic [14:0] ADDR_SENSOR_SLEEP = 15'h0401;
    localparam logic [14:0] ADDR_SYNC_FLAGS = 15'h0410;
    localparam logic [14:0] ADDR_SYSTEM_ALARMS = 15'h0430;

    localparam int RETUNE_FIELD_WIDTH = 4;
    localparam int SLEEP_BIT = 0;
    localparam int SYNC_REALIGNED = 3;
    localparam int SYNC_PHASE_MATCH = 2;
    localparam int SYNC_OSC_SEEN = 1;
    localparam int SYNC_REF_SEEN = 0;
    localparam int ALM_LINK_LOST = 7;
    localparam int ALM_LINK_TIMEOUT = 6;
    localparam int ALM_LANE_CHECKSUM = 5;
    localparam int ALM_CHIP_RESET = 1;
    localparam int ALM_REF_MISALIGN = 0;

    localparam logic [7:0] SLEEP_RESET = 8'h00;
    localparam logic [7:0] THERMAL_RESET = 8'h00;
    localparam logic [3:0] SYNC_RESET = 4'h0;
    localparam logic [3:0] SYNC_W1C_MASK = 4'hb;
    localparam logic [7:0] ALARM_RESET = 8'h02;
    localparam logic [7:0] ALARM_USED_MASK = 8'he3;
    localparam logic signed [8:0] THERMAL_OFFSET_C = 9'sh050;

    localparam int CLK_PERIOD_PS = 8000;
    localparam int TIMER_TICK_NS = 1000;
    localparam int TIMER_TICK_CYCLES = TIMER_TICK_NS * 1000 / CLK_PERIOD_PS;
    localparam logic [6:0] TICK_LAST = 7'(TIMER_TICK_CYCLES - 1);
endpackage

// [rtl/reg_access_if.sv]
// Register access strobe, address and data between the serial port and the register bank.
`timescale 1ns/100ps
interface reg_access_if;
    logic wrStb;
    logic [14:0] addr;
    logic [7:0] wrData;
    logic [7:0] rdData;
    modport port(output wrStb, output addr, output wrData, input rdData);
    modport regs(input wrStb, input addr, input wrData, output rdData);
endinterface

// [rtl/serial_reg_port.sv]
// Serial register port: 24-bit frames of read flag, 15-bit address and 8-bit data.
`timescale 1ns/100ps
module serial_reg_port
    import sync_alarm_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic sclk,
    input wire logic csN,
    input wire logic sdi,
    output logic sdo,
    output logic sdoOe,
    reg_access_if.port bus
);
    logic sclkPrev;
    logic [4:0] bitCount;
    logic [FRAME_WIDTH-1:0] rxShift;
    logic [7:0] txShift;
    logic isRead;
    logic loadPending;
    logic rise;
    logic fall;

    assign rise = !csN && sclk && !sclkPrev;
    assign fall = !csN && !sclk && sclkPrev;
    assign sdo = txShift[7];

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sclkPrev <= 1'b0;
        end else begin
            sclkPrev <= sclk;
        end
    end

    // Bits beyond the frame are ignored; streaming of several bytes is not offered.
    always_ff @(posedge clk) begin
        if (!rst_n || csN) begin
            bitCount <= 5'h00;
            rxShift <= '0;
        end else if (rise && bitCount != FRAME_BITS) begin
            bitCount <= bitCount + 5'h01;
            rxShift <= {rxShift[FRAME_WIDTH-2:0], sdi};
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            bus.addr <= '0;
            bus.wrStb <= 1'b0;
            bus.wrData <= 8'h00;
        end else begin
            bus.wrStb <= rise && !isRead && bitCount == FRAME_BITS - 5'h01;
            if (rise && bitCount == HEAD_BITS - 5'h01) begin
                bus.addr <= {rxShift[13:0], sdi};
            end
            if (rise && bitCount == FRAME_BITS - 5'h01) begin
                bus.wrData <= {rxShift[6:0], sdi};
            end
        end
    end

    // The first data bit is loaded before the next falling edge, so that edge must not shift.
    always_ff @(posedge clk) begin
        if (!rst_n || csN) begin
            isRead <= 1'b0;
            loadPending <= 1'b0;
            txShift <= 8'h00;
            sdoOe <= 1'b0;
        end else begin
            if (rise && bitCount == HEAD_BITS - 5'h01) begin
                isRead <= rxShift[14];
                loadPending <= rxShift[14];
            end else begin
                loadPending <= 1'b0;
            end
            if (loadPending) begin
                txShift <= bus.rdData;
            end else if (fall && isRead && bitCount > HEAD_BITS) begin
                txShift <= {txShift[6:0], 1'b0};
            end
            sdoOe <= isRead && bitCount >= HEAD_BITS;
        end
    end
endmodule

// [rtl/sync_status_alarm_regs.sv]
// Status, alarm and housekeeping register bank behind the serial register port.
`timescale 1ns/100ps
module sync_status_alarm_regs
    import sync_alarm_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic sclk,
    input wire logic csN,
    input wire logic sdi,
    output logic sdo,
    output logic sdoOe,
    input wire logic [RETUNE_FIELD_WIDTH-1:0] retuneAccResetField,
    input wire logic signed [7:0] tempCelsius,
    input wire logic tempDone,
    output logic sensorSleep,
    input wire logic dividerRealign,
    input wire logic frameRefPulse,
    input wire logic refPhaseMatch,
    input wire logic oscSyncEvent,
    input wire logic linkUp,
    input wire logic serialRxEnable,
    input wire logic [7:0] linkDownTimer,
    input wire logic [LANE_COUNT-1:0] laneCrcFault,
    input wire logic [LANE_COUNT-1:0] laneEnable,
    input wire logic mode64b66b,
    input wire logic softResetCmd,
    input wire logic dividerMisalign,
    input wire logic linkRefMisalign,
    output logic [DATA_WIDTH-1:0] alarmFlags
);
    reg_access_if bus();

    logic [7:0] sleepReg;
    logic [7:0] thermalReading;
    logic [3:0] syncFlags;
    logic [7:0] alarms;
    logic linkUpPrev;
    logic [6:0] tickCount;
    logic tickEn;
    logic [8:0] downTicks;
    logic signed [8:0] shiftedTemp;
    logic [7:0] next_thermal;
    logic syncWrite;
    logic alarmWrite;
    logic [3:0] syncSet;
    logic [7:0] alarmSet;
    logic timeoutHit;

    function automatic logic regWrite(input logic stb, input logic [14:0] addr,
                                      input logic [14:0] target);
        return stb && (addr == target);
    endfunction

    serial_reg_port uPort (
        .clk(clk),
        .rst_n(rst_n),
        .sclk(sclk),
        .csN(csN),
        .sdi(sdi),
        .sdo(sdo),
        .sdoOe(sdoOe),
        .bus(bus)
    );

    assign syncWrite = regWrite(bus.wrStb, bus.addr, ADDR_SYNC_FLAGS);
    assign alarmWrite = regWrite(bus.wrStb, bus.addr, ADDR_SYSTEM_ALARMS);
    assign sensorSleep = sleepReg[SLEEP_BIT];
    assign alarmFlags = alarms;

    // Sleep register; the reserved upper bits are plain storage.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sleepReg <= SLEEP_RESET;
        end else if (regWrite(bus.wrStb, bus.addr, ADDR_SENSOR_SLEEP)) begin
            sleepReg <= bus.wrData;
        end
    end

    // Sensor temperatures below -80 C clamp to zero; the top of the range never overflows.
    always_comb begin
        shiftedTemp = {tempCelsius[7], tempCelsius} + THERMAL_OFFSET_C;
        if (shiftedTemp[8]) begin
            next_thermal = 8'h00;
        end else begin
            next_thermal = shiftedTemp[7:0];
        end
    end

    // A sleeping sensor makes no conversions, so the last reading only goes stale.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            thermalReading <= THERMAL_RESET;
        end else if (tempDone && !sleepReg[SLEEP_BIT]) begin
            thermalReading <= next_thermal;
        end
    end

    always_comb begin
        syncSet = 4'h0;
        syncSet[SYNC_REALIGNED] = dividerRealign;
        syncSet[SYNC_OSC_SEEN] = oscSyncEvent;
        syncSet[SYNC_REF_SEEN] = frameRefPulse;
    end

    // Sticky sync flags except phase match: the set term is ORed after the clear, so a set is never lost.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            syncFlags <= SYNC_RESET;
        end else begin
            syncFlags <= (syncFlags & ~(syncWrite ? bus.wrData[3:0] & SYNC_W1C_MASK : 4'h0))
                | syncSet;
            if (frameRefPulse) begin
                syncFlags[SYNC_PHASE_MATCH] <= refPhaseMatch;
            end else begin
                syncFlags[SYNC_PHASE_MATCH] <= syncFlags[SYNC_PHASE_MATCH];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            linkUpPrev <= 1'b0;
        end else begin
            linkUpPrev <= linkUp;
        end
    end

    // Link timer runs in 1 us ticks so an 8-bit limit spans a useful time.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tickCount <= 7'h00;
            tickEn <= 1'b0;
        end else begin
            tickEn <= tickCount == TICK_LAST;
            if (tickCount == TICK_LAST) begin
                tickCount <= 7'h00;
            end else begin
                tickCount <= tickCount + 7'h01;
            end
        end
    end

    // The count stops one past the limit, so the alarm fires once per outage.
    always_ff @(posedge clk) begin
        if (!rst_n || linkUp || !serialRxEnable) begin
            downTicks <= 9'h000;
        end else if (tickEn && downTicks <= {1'b0, linkDownTimer}) begin
            downTicks <= downTicks + 9'h001;
        end
    end

    assign timeoutHit = tickEn && !linkUp && serialRxEnable
        && downTicks == {1'b0, linkDownTimer};

    always_comb begin
        alarmSet = 8'h00;
        alarmSet[ALM_LINK_LOST] = linkUpPrev && !linkUp && serialRxEnable;
        alarmSet[ALM_LINK_TIMEOUT] = timeoutHit;
        alarmSet[ALM_LANE_CHECKSUM] = mode64b66b && |(laneCrcFault & laneEnable);
        alarmSet[ALM_CHIP_RESET] = softResetCmd;
        alarmSet[ALM_REF_MISALIGN] = dividerMisalign
            || (linkRefMisalign && serialRxEnable);
    end

    // Chip reset itself leaves the reset alarm raised for software to see.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            alarms <= ALARM_RESET;
        end else begin
            alarms <= ((alarms & ~(alarmWrite ? bus.wrData : 8'h00)) | alarmSet)
                & ALARM_USED_MASK;
        end
    end

    // Read data is decoded from the captured address; unmapped addresses read zero.
    always_comb begin
        if (bus.addr == ADDR_RETUNE_READBACK) begin
            bus.rdData = {4'h0, retuneAccResetField};
        end else if (bus.addr == ADDR_THERMAL_READING) begin
            bus.rdData = thermalReading;
        end else if (bus.addr == ADDR_SENSOR_SLEEP) begin
            bus.rdData = sleepReg;
        end else if (bus.addr == ADDR_SYNC_FLAGS) begin
            bus.rdData = {4'h0, syncFlags};
        end else if (bus.addr == ADDR_SYSTEM_ALARMS) begin
            bus.rdData = alarms & ALARM_USED_MASK;
        end else begin
            bus.rdData = 8'h00;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    chk_retune_readback_live: assert property (
        bus.addr == ADDR_RETUNE_READBACK |-> bus.rdData == {4'h0, retuneAccResetField})
        else $error("retune readback does not follow the field");

    chk_thermal_offset_encode: assert property (
        tempDone && !sleepReg[SLEEP_BIT] && tempCelsius >= -8'sd80
        |=> thermalReading == 8'($past(tempCelsius) + 8'sd80))
        else $error("thermal reading not offset by 80");

    chk_sleep_stops_conversion: assert property (
        sleepReg[SLEEP_BIT] |=> $stable(thermalReading))
        else $error("thermal reading changed while sensor asleep");

    chk_reset_values: assert property (
        @(posedge clk) disable iff (1'b0)
        !rst_n |=> sleepReg == SLEEP_RESET && syncFlags == SYNC_RESET
            && alarms == ALARM_RESET)
        else $error("wrong values after chip reset");

    chk_realign_sticky: assert property (
        dividerRealign ##1 !(syncWrite && bus.wrData[SYNC_REALIGNED])
        |=> syncFlags[SYNC_REALIGNED])
        else $error("realign flag not held");

    chk_phase_match_track: assert property (
        frameRefPulse |=> syncFlags[SYNC_PHASE_MATCH] == $past(refPhaseMatch)
            ##1 ($past(frameRefPulse) || $stable(syncFlags[SYNC_PHASE_MATCH])))
        else $error("phase match flag wrong");

    chk_osc_write_zero: assert property (
        syncFlags[SYNC_OSC_SEEN] && syncWrite && !bus.wrData[SYNC_OSC_SEEN]
        |=> syncFlags[SYNC_OSC_SEEN])
        else $error("oscillator flag lost on write of zero");

    chk_ref_seen_clear: assert property (
        syncWrite && bus.wrData[SYNC_REF_SEEN] && !frameRefPulse
        |=> !syncFlags[SYNC_REF_SEEN])
        else $error("frame reference flag not cleared");

    chk_link_lost_set: assert property (
        $fell(linkUp) && serialRxEnable |=> alarms[ALM_LINK_LOST])
        else $error("link lost alarm missing");

    // A zero timer limit fires after a partial first tick, so it is left out here.
    chk_timeout_bound: assert property (
        timeoutHit && linkDownTimer != 8'h00 |-> !$past(linkUp) && $past(serialRxEnable))
        else $error("timeout raised without an outage");

    chk_checksum_mode: assert property (
        !alarms[ALM_LANE_CHECKSUM] && !mode64b66b |=> !alarms[ALM_LANE_CHECKSUM])
        else $error("checksum alarm outside 64b/66b mode");

    chk_set_beats_clear: assert property (
        alarmWrite && (dividerMisalign || softResetCmd)
        |=> alarms[ALM_REF_MISALIGN] || alarms[ALM_CHIP_RESET])
        else $error("set lost against clearing write");

    chk_reserved_alarm_zero: assert property (
        alarms[4:2] == 3'h0)
        else $error("reserved alarm bits set");

    cov_timeout_alarm: cover property (timeoutHit ##1 alarms[ALM_LINK_TIMEOUT]);
    cov_alarm_cleared: cover property (alarms[ALM_LINK_LOST] ##1 alarmWrite ##1 !alarms[7]);
    cov_serial_write: cover property (regWrite(bus.wrStb, bus.addr, ADDR_SENSOR_SLEEP));
    cov_checksum_alarm: cover property (!alarms[ALM_LANE_CHECKSUM] ##1 alarms[ALM_LANE_CHECKSUM]);
    cov_soft_reset: cover property (softResetCmd ##1 alarms[ALM_CHIP_RESET]);

    // Each set path must win over a clearing write that lands in the same cycle.
    chk_osc_seen_set: assert property (
        oscSyncEvent |=> syncFlags[SYNC_OSC_SEEN])
        else $error("oscillator sync flag not set");

    chk_ref_seen_set: assert property (
        frameRefPulse |=> syncFlags[SYNC_REF_SEEN])
        else $error("frame reference flag not set");

    chk_realign_clear: assert property (
        syncWrite && bus.wrData[SYNC_REALIGNED] && !dividerRealign
        |=> !syncFlags[SYNC_REALIGNED])
        else $error("realign flag not cleared by write of one");

    chk_phase_write_immune: assert property (
        syncWrite && !frameRefPulse |=> $stable(syncFlags[SYNC_PHASE_MATCH]))
        else $error("phase match flag changed by a register write");

    chk_checksum_set: assert property (
        mode64b66b && |(laneCrcFault & laneEnable) |=> alarms[ALM_LANE_CHECKSUM])
        else $error("checksum alarm not set");

    chk_checksum_lane_gate: assert property (
        !alarms[ALM_LANE_CHECKSUM] && !(|(laneCrcFault & laneEnable))
        |=> !alarms[ALM_LANE_CHECKSUM])
        else $error("checksum alarm set by a disabled lane");

    chk_soft_reset_alarm: assert property (
        softResetCmd |=> alarms[ALM_CHIP_RESET])
        else $error("reset alarm not set by software reset");

    chk_misalign_set: assert property (
        dividerMisalign || (linkRefMisalign && serialRxEnable) |=> alarms[ALM_REF_MISALIGN])
        else $error("misalignment alarm not set");

    chk_misalign_rx_gate: assert property (
        !alarms[ALM_REF_MISALIGN] && !dividerMisalign && !serialRxEnable
        |=> !alarms[ALM_REF_MISALIGN])
        else $error("misalignment alarm set with receiver off");

    chk_link_lost_gate: assert property (
        !alarms[ALM_LINK_LOST] && !serialRxEnable |=> !alarms[ALM_LINK_LOST])
        else $error("link lost alarm set with receiver off");

    chk_timeout_alarm_set: assert property (
        timeoutHit |=> alarms[ALM_LINK_TIMEOUT])
        else $error("timeout alarm not set");

    chk_alarm_write_clear: assert property (
        alarmWrite && bus.wrData[ALM_LINK_LOST] && !($fell(linkUp) && serialRxEnable)
        |=> !alarms[ALM_LINK_LOST])
        else $error("link lost alarm not cleared by write of one");

    chk_sleep_write: assert property (
        regWrite(bus.wrStb, bus.addr, ADDR_SENSOR_SLEEP) |=> sleepReg == $past(bus.wrData))
        else $error("sleep register write lost");

    chk_thermal_clamp: assert property (
        tempDone && !sleepReg[SLEEP_BIT] && tempCelsius < -8'sd80 |=> thermalReading == 8'h00)
        else $error("thermal reading not clamped below range");

    chk_alarm_readback: assert property (
        bus.addr == ADDR_SYSTEM_ALARMS |-> bus.rdData == alarms && bus.rdData[4:2] == 3'h0)
        else $error("alarm readback wrong");
endmodule

// [sim/serial_host.sv]
// Host-side serial register master that drives frames into the status block.
`timescale 1ns/100ps
module serial_host (
    input wire logic clk,
    input wire logic sdo,
    input wire logic sdoOe,
    output logic sclk,
    output logic csN,
    output logic sdi
);
    // A released data line floats high through a pull-up, so stale bits never look valid.
    wire sdoLine = sdoOe ? sdo : 1'b1;

    initial begin
        sclk = 1'b0;
        csN = 1'b1;
        sdi = 1'b0;
    end

    // The half period is given per access, so slow reads simply pass a larger one.
    task automatic xfer(input logic rd, input logic [14:0] a, input logic [7:0] wd,
                        input int half, output logic [7:0] rv);
        logic [23:0] f;
        f = {rd, a, wd};
        rv = 8'h00;
        @(negedge clk) csN = 1'b0;
        for (int i = 23; i >= 0; i--) begin
            @(negedge clk);
            sclk = 1'b0;
            sdi = f[i];
            repeat (half) @(negedge clk);
            sclk = 1'b1;
            if (i < 8) rv[i] = sdoLine;
            repeat (half) @(negedge clk);
        end
        sclk = 1'b0;
        repeat (half) @(negedge clk);
        csN = 1'b1;
        repeat (3) @(negedge clk);
    endtask
endmodule

// [sim/tb_sync_status_alarm_regs.sv]
// Self-checking bench for the status and alarm register bank.
`timescale 1ns/100ps
module tb_sync_status_alarm_regs;
    import sync_alarm_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic sclk, csN, sdi, sdo, sdoOe, sensorSleep;
    logic [3:0] field = 4'h0;
    logic signed [7:0] temp = 8'sh00;
    logic [6:0] ev = 7'h00;
    logic match = 1'b0;
    logic linkUp = 1'b0;
    logic rxEn = 1'b0;
    logic mode66 = 1'b0;
    logic [7:0] timer = 8'h01;
    logic [15:0] crc = 16'h0000;
    logic [15:0] laneEn = 16'h0000;
    logic [7:0] alarmFlags;
    int num_errors = 0;
    int samples_checked = 0;
    int t;
    int n;

    always #4 clk = ~clk;

    serial_host host (.clk(clk), .sdo(sdo), .sdoOe(sdoOe), .sclk(sclk), .csN(csN), .sdi(sdi));

    sync_status_alarm_regs uut (
        .clk(clk), .rst_n(rst_n), .sclk(sclk), .csN(csN), .sdi(sdi), .sdo(sdo),
        .sdoOe(sdoOe), .retuneAccResetField(field), .tempCelsius(temp),
        .tempDone(ev[0]), .sensorSleep(sensorSleep), .dividerRealign(ev[1]),
        .frameRefPulse(ev[2]), .refPhaseMatch(match), .oscSyncEvent(ev[3]),
        .linkUp(linkUp), .serialRxEnable(rxEn), .linkDownTimer(timer),
        .laneCrcFault(crc), .laneEnable(laneEn), .mode64b66b(mode66),
        .softResetCmd(ev[4]), .dividerMisalign(ev[5]), .linkRefMisalign(ev[6]),
        .alarmFlags(alarmFlags)
    );

    function automatic logic [7:0] tempCode(input int c);
        return (c < -80) ? 8'h00 : 8'(c + 80);
    endfunction

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic rd(input logic [14:0] a, input logic [7:0] e, input int h = 4);
        logic [7:0] v;
        host.xfer(1'b1, a, 8'h00, h, v);
        chk(v, e);
    endtask

    task automatic wr(input logic [14:0] a, input logic [7:0] d);
        logic [7:0] v;
        host.xfer(1'b0, a, d, 4, v);
    endtask

    task automatic pulse(input int b);
        @(negedge clk) ev[b] = 1'b1;
        @(negedge clk) ev[b] = 1'b0;
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        void'($urandom(8));
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        begin : tests
            rd(ADDR_SENSOR_SLEEP, 8'h00);
            rd(ADDR_SYSTEM_ALARMS, 8'h02);
            rd(ADDR_SYNC_FLAGS, 8'h00);
            chk({7'h00, sensorSleep}, 8'h00);
            wr(15'h0123, 8'h5a);
            rd(15'h0123, 8'h00);
            $display("test reset done");
            for (int i = 0; i < 6; i++) begin
                // The field is held steady for the whole read.
                field = 4'($urandom);
                rd(ADDR_RETUNE_READBACK, {4'h0, field});
            end
            $display("test readback done");
            for (int i = 0; i < 7; i++) begin
                t = (i == 0) ? -80 : (i == 1) ? 30 : (i == 2) ? 127 : (i == 3) ? -100
                    : $urandom_range(207) - 80;
                temp = 8'(t);
                pulse(0);
                rd(ADDR_THERMAL_READING, tempCode(t), 8);
            end
            wr(ADDR_THERMAL_READING, 8'h55);
            rd(ADDR_THERMAL_READING, tempCode(t), 8);
            wr(ADDR_SENSOR_SLEEP, 8'h01);
            chk({7'h00, sensorSleep}, 8'h01);
            rd(ADDR_SENSOR_SLEEP, 8'h01);
            temp = 8'sh00;
            pulse(0);
            rd(ADDR_THERMAL_READING, tempCode(t), 8);
            wr(ADDR_SENSOR_SLEEP, 8'h00);
            $display("test thermal done");
            match = 1'b1;
            pulse(1);
            pulse(2);
            pulse(3);
            rd(ADDR_SYNC_FLAGS, 8'h0f);
            wr(ADDR_SYNC_FLAGS, 8'h00);
            rd(ADDR_SYNC_FLAGS, 8'h0f);
            wr(ADDR_SYNC_FLAGS, 8'h08);
            rd(ADDR_SYNC_FLAGS, 8'h07);
            wr(ADDR_SYNC_FLAGS, 8'h02);
            rd(ADDR_SYNC_FLAGS, 8'h05);
            wr(ADDR_SYNC_FLAGS, 8'h01);
            rd(ADDR_SYNC_FLAGS, 8'h04);
            wr(ADDR_SYNC_FLAGS, 8'hff);
            rd(ADDR_SYNC_FLAGS, 8'h04);
            match = 1'b0;
            pulse(2);
            rd(ADDR_SYNC_FLAGS, 8'h01);
            wr(ADDR_SYNC_FLAGS, 8'hff);
            rd(ADDR_SYNC_FLAGS, 8'h00);
            $display("test sync done");
            wr(ADDR_SYSTEM_ALARMS, 8'h02);
            rd(ADDR_SYSTEM_ALARMS, 8'h00);
            linkUp = 1'b1;
            repeat (2) @(negedge clk);
            linkUp = 1'b0;
            repeat (300) @(negedge clk);
            chk(alarmFlags, 8'h00);
            linkUp = 1'b1;
            rxEn = 1'b1;
            repeat (2) @(negedge clk);
            linkUp = 1'b0;
            n = 0;
            while (alarmFlags[6] !== 1'b1 && n < 400) begin
                @(negedge clk);
                n++;
            end
            if (n >= 400) begin
                chk(8'h01, 8'h00);
                disable tests;
            end
            chk({7'h00, n >= TIMER_TICK_CYCLES * timer
                && n <= TIMER_TICK_CYCLES * (timer + 1) + 10}, 8'h01);
            chk(alarmFlags, 8'hc0);
            linkUp = 1'b1;
            wr(ADDR_SYSTEM_ALARMS, 8'hc0);
            rd(ADDR_SYSTEM_ALARMS, 8'h00);
            laneEn = 16'($urandom) | 16'h0001;
            crc = ~laneEn;
            mode66 = 1'b1;
            repeat (2) @(negedge clk);
            crc = laneEn & (~laneEn + 16'h0001);
            mode66 = 1'b0;
            repeat (2) @(negedge clk);
            chk(alarmFlags, 8'h00);
            mode66 = 1'b1;
            repeat (2) @(negedge clk);
            crc = 16'h0000;
            chk(alarmFlags, 8'h20);
            pulse(5);
            chk(alarmFlags, 8'h21);
            wr(ADDR_SYSTEM_ALARMS, 8'h21);
            rxEn = 1'b0;
            pulse(6);
            chk(alarmFlags, 8'h00);
            rxEn = 1'b1;
            pulse(6);
            chk(alarmFlags, 8'h01);
            @(negedge clk) ev[5] = 1'b1;
            wr(ADDR_SYSTEM_ALARMS, 8'h01);
            ev[5] = 1'b0;
            chk(alarmFlags, 8'h01);
            wr(ADDR_SYSTEM_ALARMS, 8'h1c);
            rd(ADDR_SYSTEM_ALARMS, 8'h01);
            wr(ADDR_SYSTEM_ALARMS, 8'h01);
            pulse(4);
            chk(alarmFlags, 8'h02);
            $display("test alarms done");
            pulse(1);
            wr(ADDR_SENSOR_SLEEP, 8'h01);
            @(negedge clk) rst_n = 1'b0;
            repeat (2) @(negedge clk);
            rst_n = 1'b1;
            @(negedge clk);
            chk({7'h00, sensorSleep}, 8'h00);
            rd(ADDR_SYNC_FLAGS, 8'h00);
            rd(ADDR_SYSTEM_ALARMS, 8'h02);
            $display("test second reset done");
        end
        complete_run();
    end
endmodule
